/* logic/mds_pkg.sv */
// Shared constants and types for the multi-controller select and pixel steering glue.
package mds_pkg;

  // ----------------------------------------------------------------
  // Structure of the controller group
  // ----------------------------------------------------------------
  localparam int unsigned MDS_CTRL_N = 4;
  localparam int unsigned MDS_PLANES = 4;
  localparam int unsigned MDS_WORD_W = 16;
  localparam int unsigned MDS_NIB_W = 4;
  localparam int unsigned MDS_SEL_N = 5;
  localparam int unsigned MDS_BCAST_IDX = 4;
  localparam int unsigned MDS_XCVR_PER_CTRL = 2;
  localparam int unsigned MDS_PIX_XCVR_N = 2;

  // Register-select code of the block transfer buffer.
  localparam logic [1:0] MDS_FIFO_REGSEL = 2'h3;

  // ----------------------------------------------------------------
  // Wishbone register map
  // ----------------------------------------------------------------
  localparam int unsigned MDS_WB_AW = 4;
  localparam logic [3:0] MDS_ADR_ACT = 4'h0;
  localparam logic [3:0] MDS_ADR_STAT = 4'h4;
  localparam logic [15:0] MDS_ACT_RESET = 16'hffff;
  localparam int unsigned MDS_STAT_STATE_LSB = 0;
  localparam int unsigned MDS_STAT_EDE_LSB = 4;
  localparam int unsigned MDS_STAT_CS_LSB = 8;
  localparam int unsigned MDS_STAT_PIX_LSB = 12;
  localparam int unsigned MDS_STAT_RD_LSB = 13;

  // ----------------------------------------------------------------
  // Host bus state tracker, Gray coded along the read path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MDS_ST_IDLE = 3'h0,
    MDS_ST_T1 = 3'h1,
    MDS_ST_T2 = 3'h3,
    MDS_ST_T3 = 3'h2,
    MDS_ST_TW = 3'h6,
    MDS_ST_T4 = 3'h7
  } mds_bus_state_type;

endpackage

/* logic/mds_plane_ctrl.sv */
// One graphics controller's plane store, driver enable and pixel shifter.
`timescale 1ns/1ps
`default_nettype none
module mds_plane_ctrl (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic select_in,
  input wire logic [1:0] reg_sel_in,
  input wire logic [mds_pkg::MDS_PLANES-1:0] plane_activity_bits_in,
  input wire logic by_pixel_in,
  input wire logic write_pulse_in,
  input wire logic read_done_in,
  input wire logic [mds_pkg::MDS_WORD_W-1:0] wr_data_in,
  output logic external_driver_enable_out,
  output logic [mds_pkg::MDS_WORD_W-1:0] rd_word_out
);
  import mds_pkg::*;

  logic [MDS_WORD_W-1:0] plane_mem [0:MDS_PLANES-1];
  logic fifo_hit;

  // ----------------------------------------------------------------
  // Driver enable
  // ----------------------------------------------------------------
  // Only buffer accesses with some plane active may drive the bus.
  assign fifo_hit = select_in && (reg_sel_in == MDS_FIFO_REGSEL);
  assign external_driver_enable_out = fifo_hit && (|plane_activity_bits_in);

  // ----------------------------------------------------------------
  // Plane store
  // ----------------------------------------------------------------
  // A by-pixel write shifts one bit into each active plane; a read rotates.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int p = 0; p < MDS_PLANES; p++) begin
        plane_mem[p] <= '0;
      end
    end else if (clk_en_in) begin
      for (int p = 0; p < MDS_PLANES; p++) begin
        if (write_pulse_in && fifo_hit && plane_activity_bits_in[p]) begin
          if (by_pixel_in) begin
            plane_mem[p] <= {plane_mem[p][MDS_WORD_W-2:0], wr_data_in[MDS_WORD_W-MDS_NIB_W+p]};
          end else begin
            plane_mem[p] <= wr_data_in;
          end
        end else if (read_done_in && fifo_hit && by_pixel_in) begin
          plane_mem[p] <= {plane_mem[p][MDS_WORD_W-2:0], plane_mem[p][MDS_WORD_W-1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read word
  // ----------------------------------------------------------------
  // Pixel k sits in nibble 3-k, so a one-bit plane shift moves the word by four.
  always_comb begin
    rd_word_out = '1;
    if (by_pixel_in) begin
      for (int k = 0; k < MDS_NIB_W; k++) begin
        for (int p = 0; p < MDS_PLANES; p++) begin
          rd_word_out[MDS_NIB_W*(MDS_NIB_W-1-k)+p] =
            plane_activity_bits_in[p] ? plane_mem[p][MDS_WORD_W-1-k] : 1'b1;
        end
      end
    end else begin
      for (int p = MDS_PLANES - 1; p >= 0; p--) begin
        if (plane_activity_bits_in[p]) begin
          rd_word_out = plane_mem[p];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ede_cause;
    @(posedge clock_in) disable iff (!rst_b_in)
    external_driver_enable_out |-> select_in && (&reg_sel_in) && (|plane_activity_bits_in);
  endproperty
  a_ede_cause: assert property (p_ede_cause) else $error("driver enable without cause");

endmodule // mds_plane_ctrl
`default_nettype wire

/* logic/mds_select_steer.sv */
// Chip select decode, bus state tracking and transceiver steering for four controllers.
`timescale 1ns/1ps
`default_nettype none
module mds_select_steer #(
  parameter int unsigned CTRL_N = mds_pkg::MDS_CTRL_N,
  parameter int unsigned WORD_W = mds_pkg::MDS_WORD_W
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [mds_pkg::MDS_WB_AW-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [mds_pkg::MDS_SEL_N-1:0] peripheral_select_line_b_in,
  input wire logic addr_latch_en_in,
  input wire logic host_data_bus_enable_b_in,
  input wire logic read_strobe_b_in,
  input wire logic [3:1] host_addr_in,
  input wire logic [mds_pkg::MDS_WORD_W-1:0] host_data_in,
  output logic [mds_pkg::MDS_WORD_W-1:0] host_data_out,
  output logic host_data_oe_out,
  output logic [mds_pkg::MDS_CTRL_N-1:0] ctrl_select_b_out,
  output logic [1:0] reg_sel_out,
  output logic [mds_pkg::MDS_CTRL_N*mds_pkg::MDS_XCVR_PER_CTRL-1:0] regular_xcvr_en_b_out,
  output logic [mds_pkg::MDS_PIX_XCVR_N-1:0] pixel_xcvr_en_b_out,
  output logic xcvr_to_host_out,
  output logic fourth_bus_state_out
);
  import mds_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The decode is wired for exactly four controllers sharing one word.
  if (CTRL_N != MDS_CTRL_N || WORD_W != CTRL_N * MDS_NIB_W) begin : g_bad_size
    $error("mds_select_steer supports four controllers of four planes only");
  end

  mds_bus_state_type state;
  mds_bus_state_type next_state;
  logic cyc_rd;
  logic a3_lat;
  logic [MDS_CTRL_N-1:0] cs;
  logic pix_mode;
  logic [MDS_WORD_W-1:0] act_bits;
  logic [MDS_CTRL_N-1:0] ede;
  logic [MDS_WORD_W-1:0] ctrl_word [0:MDS_CTRL_N-1];
  logic [MDS_WORD_W-1:0] ctrl_wdata [0:MDS_CTRL_N-1];
  logic [MDS_SEL_N-1:0] sel_act;
  logic host_data_bus_enable;
  logic rd_gate;
  logic wr_gate;
  logic [MDS_CTRL_N-1:0] reg_en;
  logic pix_en;
  logic wr_pulse;
  logic rd_done;
  logic next_oe;
  logic [MDS_WORD_W-1:0] next_rdata;
  logic wb_req;

  assign sel_act = ~peripheral_select_line_b_in;
  assign host_data_bus_enable = !host_data_bus_enable_b_in;

  // ----------------------------------------------------------------
  // Host bus state tracker
  // ----------------------------------------------------------------
  // The fourth state exists only on reads, so writes end on the data enable.
  always_comb begin
    next_state = state;
    case (state)
      MDS_ST_IDLE: next_state = addr_latch_en_in ? MDS_ST_T1 : MDS_ST_IDLE;
      MDS_ST_T1: next_state = MDS_ST_T2;
      MDS_ST_T2: next_state = MDS_ST_T3;
      MDS_ST_T3: next_state = !read_strobe_b_in ? MDS_ST_TW : MDS_ST_IDLE;
      MDS_ST_TW: next_state = MDS_ST_T4;
      MDS_ST_T4: next_state = addr_latch_en_in ? MDS_ST_T1 : MDS_ST_IDLE;
      default: next_state = MDS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state <= MDS_ST_IDLE;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  // A cycle counts as a read once the read strobe is seen after the latch strobe.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cyc_rd <= 1'b0;
    end else if (clk_en_in) begin
      if (addr_latch_en_in) begin
        cyc_rd <= 1'b0;
      end else if (!read_strobe_b_in) begin
        cyc_rd <= 1'b1;
      end
    end
  end

  assign fourth_bus_state_out = (state == MDS_ST_T4);

  // ----------------------------------------------------------------
  // Address latch and chip selects
  // ----------------------------------------------------------------
  // Register-select follows the latch strobe, so it settles before any select.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      reg_sel_out <= 2'h0;
      a3_lat <= 1'b0;
    end else if (clk_en_in && addr_latch_en_in) begin
      reg_sel_out <= host_addr_in[2:1];
      a3_lat <= host_addr_in[3];
    end
  end

  // Broadcast select folds into every controller select, all held off by the strobe.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cs <= '0;
      pix_mode <= 1'b0;
    end else if (clk_en_in) begin
      for (int i = 0; i < MDS_CTRL_N; i++) begin
        cs[i] <= (sel_act[i] || sel_act[MDS_BCAST_IDX]) && !addr_latch_en_in;
      end
      pix_mode <= sel_act[MDS_BCAST_IDX] && !addr_latch_en_in && a3_lat;
    end
  end

  assign ctrl_select_b_out = ~cs;

  // ----------------------------------------------------------------
  // Transceiver steering
  // ----------------------------------------------------------------
  // Reads drop at the fourth state to free the bus before the next address phase.
  assign rd_gate = host_data_bus_enable && cyc_rd && (state != MDS_ST_T4);
  assign wr_gate = host_data_bus_enable && !cyc_rd;

  always_comb begin
    for (int i = 0; i < MDS_CTRL_N; i++) begin
      reg_en[i] = cs[i] && !pix_mode && (wr_gate || (rd_gate && ede[i]));
    end
  end

  assign pix_en = pix_mode && (&cs) && (wr_gate || (rd_gate && (&ede)));

  always_comb begin
    for (int i = 0; i < MDS_CTRL_N; i++) begin
      for (int b = 0; b < MDS_XCVR_PER_CTRL; b++) begin
        regular_xcvr_en_b_out[i*MDS_XCVR_PER_CTRL+b] = !reg_en[i];
      end
    end
  end

  assign pixel_xcvr_en_b_out = pix_en ? '0 : '1;
  assign xcvr_to_host_out = cyc_rd;

  // ----------------------------------------------------------------
  // Data paths
  // ----------------------------------------------------------------
  // By-pixel writes hand nibble k to controller k in its top nibble position.
  always_comb begin
    for (int i = 0; i < MDS_CTRL_N; i++) begin
      ctrl_wdata[i] = host_data_in;
      if (pix_mode) begin
        ctrl_wdata[i] = {host_data_in[MDS_NIB_W*i +: MDS_NIB_W],
                         {(MDS_WORD_W-MDS_NIB_W){1'b0}}};
      end
    end
  end

  // By-pixel reads take the top nibble of each controller; plane reads take the driver.
  always_comb begin
    next_rdata = '0;
    next_oe = 1'b0;
    if (pix_en && cyc_rd) begin
      next_oe = 1'b1;
      for (int i = 0; i < MDS_CTRL_N; i++) begin
        next_rdata[MDS_NIB_W*i +: MDS_NIB_W] =
          ctrl_word[i][MDS_WORD_W-MDS_NIB_W +: MDS_NIB_W];
      end
    end else begin
      for (int i = 0; i < MDS_CTRL_N; i++) begin
        if (reg_en[i] && cyc_rd) begin
          next_oe = 1'b1;
          next_rdata = next_rdata | ctrl_word[i];
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      host_data_out <= '0;
      host_data_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      host_data_out <= next_rdata;
      host_data_oe_out <= next_oe;
    end
  end

  // Writes land in T3; by-pixel read shifts happen once, at the fourth state.
  assign wr_pulse = (state == MDS_ST_T3) && !cyc_rd && host_data_bus_enable;
  assign rd_done = (state == MDS_ST_T4) && pix_mode;

  // ----------------------------------------------------------------
  // Controllers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < MDS_CTRL_N; g++) begin : g_ctrl
    mds_plane_ctrl u_ctrl (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .clk_en_in(clk_en_in),
      .select_in(cs[g]),
      .reg_sel_in(reg_sel_out),
      .plane_activity_bits_in(act_bits[MDS_PLANES*g +: MDS_PLANES]),
      .by_pixel_in(pix_mode),
      .write_pulse_in(wr_pulse),
      .read_done_in(rd_done),
      .wr_data_in(ctrl_wdata[g]),
      .external_driver_enable_out(ede[g]),
      .rd_word_out(ctrl_word[g])
    );
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Zero-wait answers: ack follows the request by one edge, then drops.
  assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
    end else if (clk_en_in) begin
      wb_ack_out <= wb_req;
    end
  end

  // Software keeps one activity bit set before plane reads; nothing here enforces it.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      act_bits <= MDS_ACT_RESET;
    end else if (clk_en_in && wb_req && wb_we_in && wb_adr_in == MDS_ADR_ACT) begin
      for (int b = 0; b < MDS_WORD_W / 8; b++) begin
        if (wb_sel_in[b]) begin
          act_bits[8*b +: 8] <= wb_dat_in[8*b +: 8];
        end
      end
    end
  end

  // Unmapped offsets read zero and ignore writes, but are still acknowledged.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      wb_dat_out <= 32'h0;
    end else if (clk_en_in && wb_req) begin
      wb_dat_out <= 32'h0;
      if (wb_adr_in == MDS_ADR_ACT) begin
        wb_dat_out[MDS_WORD_W-1:0] <= act_bits;
      end else if (wb_adr_in == MDS_ADR_STAT) begin
        wb_dat_out[MDS_STAT_STATE_LSB +: 3] <= state;
        wb_dat_out[MDS_STAT_EDE_LSB +: MDS_CTRL_N] <= ede;
        wb_dat_out[MDS_STAT_CS_LSB +: MDS_CTRL_N] <= cs;
        wb_dat_out[MDS_STAT_PIX_LSB] <= pix_mode;
        wb_dat_out[MDS_STAT_RD_LSB] <= cyc_rd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rd_needs_ede;
    @(posedge clock_in) disable iff (!rst_b_in)
    (cyc_rd && (regular_xcvr_en_b_out != '1)) |-> host_data_bus_enable && ((ede & cs) != '0);
  endproperty
  a_rd_needs_ede: assert property (p_rd_needs_ede) else $error("read xcvr without ede");

  property p_t4_off;
    @(posedge clock_in) disable iff (!rst_b_in)
    (state == MDS_ST_TW && clk_en_in) |=> fourth_bus_state_out
      && (&regular_xcvr_en_b_out) && (&pixel_xcvr_en_b_out);
  endproperty
  a_t4_off: assert property (p_t4_off) else $error("xcvr on in fourth state");

  property p_wr_follows_den;
    @(posedge clock_in) disable iff (!rst_b_in)
    (!cyc_rd && cs[0] && !pix_mode) |-> (regular_xcvr_en_b_out[1:0] == 2'h0) == host_data_bus_enable;
  endproperty
  a_wr_follows_den: assert property (p_wr_follows_den) else $error("write gating");

  property p_bcast_all;
    @(posedge clock_in) disable iff (!rst_b_in || !clk_en_in)
    (sel_act[MDS_BCAST_IDX] && !addr_latch_en_in && clk_en_in) |=> (ctrl_select_b_out == '0);
  endproperty
  a_bcast_all: assert property (p_bcast_all) else $error("broadcast missed a select");

  property p_cs_cause;
    @(posedge clock_in) disable iff (!rst_b_in || !clk_en_in)
    (!ctrl_select_b_out[1] && $past(clk_en_in)) |->
      $past(!addr_latch_en_in && (sel_act[1] || sel_act[MDS_BCAST_IDX]));
  endproperty
  a_cs_cause: assert property (p_cs_cause) else $error("select without cause");

  property p_regsel_latch;
    @(posedge clock_in) disable iff (!rst_b_in)
    (addr_latch_en_in && clk_en_in) |=> reg_sel_out == $past(host_addr_in[2:1]);
  endproperty
  a_regsel_latch: assert property (p_regsel_latch) else $error("register select not latched");

  property p_pix_only_bcast;
    @(posedge clock_in) disable iff (!rst_b_in)
    (pixel_xcvr_en_b_out != '1) |-> pix_mode && a3_lat && (regular_xcvr_en_b_out == '1);
  endproperty
  a_pix_only_bcast: assert property (p_pix_only_bcast) else $error("pixel xcvr misuse");

  property p_single_only;
    @(posedge clock_in) disable iff (!rst_b_in)
    (regular_xcvr_en_b_out[5:4] != 2'h3) |-> cs[2] && !pix_mode;
  endproperty
  a_single_only: assert property (p_single_only) else $error("foreign xcvr enabled");

  property p_pix_read_data;
    @(posedge clock_in) disable iff (!rst_b_in)
    (pix_en && cyc_rd && clk_en_in) |=> host_data_oe_out
      && host_data_out[3:0] == $past(ctrl_word[0][15:12]);
  endproperty
  a_pix_read_data: assert property (p_pix_read_data) else $error("pixel nibble wrong");

  property p_wb_ack;
    @(posedge clock_in) disable iff (!rst_b_in)
    (wb_req && clk_en_in) |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack timing");

  c_pix_read: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    pix_en && cyc_rd ##[1:4] fourth_bus_state_out);
  c_bcast_write: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    wr_pulse && (&cs));
  c_single_read: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    reg_en[0] && cyc_rd && !cs[1]);

endmodule // mds_select_steer
`default_nettype wire

/* verification/mds_host_model.sv */
// Host processor bus model that runs select, latch strobe, data enable and read cycles.
`timescale 1ns/1ps
`default_nettype none
module mds_host_model (
  input wire logic clock_in,
  input wire logic [3:0] sel_b_in,
  input wire logic [7:0] reg_en_b_in,
  input wire logic [1:0] pix_en_b_in,
  input wire logic [15:0] rd_data_in,
  input wire logic t4_in,
  output logic [4:0] pcs_b_out,
  output logic ale_out,
  output logic den_b_out,
  output logic rd_b_out,
  output logic [2:0] addr_out,
  output logic [15:0] data_out
);
  logic [3:0] sel_ale;
  logic [3:0] sel_t2;
  logic [9:0] en_t3;
  logic [9:0] en_t4;
  logic [15:0] rdat;
  logic t4;

  // Idle bus at time zero: nothing selected, strobes inactive.
  initial begin
    pcs_b_out = 5'h1f;
    ale_out = 1'b0;
    den_b_out = 1'b1;
    rd_b_out = 1'b1;
    addr_out = 3'h0;
    data_out = 16'h0;
  end

  // One host cycle; the select is asserted with the strobe so that
  // the glue's own qualification is what keeps the select quiet.
  task automatic bus(input int blk, input logic [2:0] a, input logic rd,
                     input logic [15:0] d);
    @(posedge clock_in);
    ale_out <= 1'b1;
    addr_out <= a;
    pcs_b_out <= ~(5'h01 << blk);
    @(posedge clock_in);
    ale_out <= 1'b0;
    den_b_out <= 1'b0;
    rd_b_out <= ~rd;
    data_out <= d;
    @(negedge clock_in);
    sel_ale = sel_b_in;
    @(posedge clock_in);
    @(negedge clock_in);
    sel_t2 = sel_b_in;
    @(posedge clock_in);
    @(negedge clock_in);
    en_t3 = {pix_en_b_in, reg_en_b_in};
    if (rd) begin
      @(posedge clock_in);
      @(negedge clock_in);
      rdat = rd_data_in;
      @(posedge clock_in);
      @(negedge clock_in);
      t4 = t4_in;
      en_t4 = {pix_en_b_in, reg_en_b_in};
    end
    // Released data lines show the inverse so stale values cannot pass.
    @(posedge clock_in);
    pcs_b_out <= 5'h1f;
    den_b_out <= 1'b1;
    rd_b_out <= 1'b1;
    data_out <= ~d;
  endtask
endmodule // mds_host_model
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the select and pixel steering glue.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mds_pkg::*;
  logic clock_in, rst_b, wb_cyc, wb_stb, wb_we;
  logic [3:0] wb_adr;
  logic [31:0] wb_dat, wb_q, rd_q;
  logic ack, oe, xdir, t4;
  logic [4:0] pcs_b;
  logic ale, den_b, rd_b;
  logic [2:0] haddr;
  logic [15:0] hwd, hrd;
  logic [3:0] sel_b;
  logic [1:0] rs, pix_b;
  logic [7:0] reg_b;
  int n_fail, total_checks, cycles, b, a3;

  mds_select_steer u_mds_select_steer (.clock_in(clock_in), .rst_b_in(rst_b),
    .clk_en_in(1'b1), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(4'hf), .wb_dat_in(wb_dat), .wb_dat_out(wb_q),
    .wb_ack_out(ack), .peripheral_select_line_b_in(pcs_b), .addr_latch_en_in(ale),
    .host_data_bus_enable_b_in(den_b), .read_strobe_b_in(rd_b),
    .host_addr_in(haddr), .host_data_in(hwd), .host_data_out(hrd),
    .host_data_oe_out(oe), .ctrl_select_b_out(sel_b), .reg_sel_out(rs),
    .regular_xcvr_en_b_out(reg_b), .pixel_xcvr_en_b_out(pix_b),
    .xcvr_to_host_out(xdir), .fourth_bus_state_out(t4));

  mds_host_model u_mds_host_model (.clock_in(clock_in), .sel_b_in(sel_b),
    .reg_en_b_in(reg_b), .pix_en_b_in(pix_b), .rd_data_in(hrd), .t4_in(t4),
    .pcs_b_out(pcs_b), .ale_out(ale), .den_b_out(den_b), .rd_b_out(rd_b),
    .addr_out(haddr), .data_out(hwd));

  // ----------------------------------------------------------------
  // Clock, timeout and common tasks
  // ----------------------------------------------------------------
  // The clock runs at 25 MHz.
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // A hung handshake is cut off well beyond the roughly 120 cycles needed.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic Wishbone cycle; waits for ack without assuming a latency.
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clock_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clock_in);
      if (ack === 1'b1) break;
    end
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock_in);
    if (n == 20) n_fail++;
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
    rst_b = 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b <= 1'b1;
    @(negedge clock_in);
    check({oe, sel_b, reg_b, pix_b}, 15'h3fff);
    wb(1'b0, MDS_ADR_ACT, 32'h0, rd_q);
    check(rd_q, 32'(MDS_ACT_RESET));
    wb(1'b0, 4'h8, 32'h0, rd_q);
    check(rd_q, 32'h0);
    // Every select block with address bit three low and high.
    for (int i = 0; i < 10; i++) begin
      b = i % 5;
      a3 = i / 5;
      u_mds_host_model.bus(b, {a3[0], b[1:0]}, 1'b0, 16'h0);
      check(u_mds_host_model.sel_ale, 4'hf);
      check(u_mds_host_model.sel_t2, b == 4 ? 4'h0 : 4'(~(4'h1 << b)));
      check(rs, b[1:0]);
      check(u_mds_host_model.en_t3[9:8], (b == 4 && a3 == 1) ? 2'h0 : 2'h3);
      if (!(b == 4 && a3 == 1))
        check(u_mds_host_model.en_t3[7:0], b == 4 ? 8'h0 : 8'(~(8'h03 << 2 * b)));
    end
    // Planes 0 and 1 of controller 0 take the write, planes 2 and 3 do not.
    wb(1'b1, MDS_ADR_ACT, 32'hffe3, rd_q);
    u_mds_host_model.bus(0, 3'h3, 1'b0, 16'h8000);
    wb(1'b1, MDS_ADR_ACT, 32'hffef, rd_q);
    u_mds_host_model.bus(4, 3'h7, 1'b1, 16'h0);
    check(u_mds_host_model.en_t3[9:8], 2'h0);
    check(u_mds_host_model.rdat, 16'h0013);
    check(u_mds_host_model.t4, 1'b1);
    check(u_mds_host_model.en_t4, 10'h3ff);
    check(xdir, 1'b1);
    u_mds_host_model.bus(4, 3'h7, 1'b1, 16'h0);
    check(u_mds_host_model.rdat, 16'h0010);
    // By-plane reads: only a controller with an active plane opens its path.
    wb(1'b1, MDS_ADR_ACT, 32'h0001, rd_q);
    u_mds_host_model.bus(0, 3'h3, 1'b1, 16'h0);
    check(u_mds_host_model.en_t3, 10'h3fc);
    wb(1'b1, MDS_ADR_ACT, 32'h0010, rd_q);
    u_mds_host_model.bus(0, 3'h3, 1'b1, 16'h0);
    check(u_mds_host_model.en_t3, 10'h3ff);
    // Tracker is idle again, selects are off and only the read flag remains.
    wb(1'b0, MDS_ADR_STAT, 32'h0, rd_q);
    check(rd_q, 32'h2000);
    u_mds_host_model.bus(0, 3'h3, 1'b0, 16'h0);
    check(u_mds_host_model.en_t3, 10'h3fc);
    check(xdir, 1'b0);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
